// *** pkg/fiq_consts.svh ***
// Sizes, widths and cycle counts of the floating-point issue queue.
// Assumes inclusion by bare name from pkg/ on the include path.
`ifndef FIQ_CONSTS_SVH
`define FIQ_CONSTS_SVH

`define FIQ_ENTRIES    15
`define FIQ_IDX_W      4
`define FIQ_PREGS      72
`define FIQ_PREG_W     7
`define FIQ_DATA_W     64
`define FIQ_IQ_IDX_W   5
`define FIQ_ADD_LAT    4
`define FIQ_MUL_LAT    4
// Divide and square-root occupancy in cycles; must exceed the add latency
`define FIQ_DSQ_LAT    5'h0C
`define FIQ_DSQ_CLASH  5'h05
`define FIQ_EVEN_MASK  15'h5555
`define FIQ_ODD_MASK   15'h2AAA

`endif

// *** pkg/fiq_pkg.sv ***
// Types shared by the floating-point issue queue and its arbiter.
// Assumes nothing beyond the constants header.
`default_nettype none

package fiq_pkg;

    // Instruction classes the queue takes
    typedef enum logic [1:0] {
        FIQ_CLS_OP   = 2'h0,
        FIQ_CLS_BR   = 2'h1,
        FIQ_CLS_ST   = 2'h2,
        FIQ_CLS_FTOI = 2'h3
    } fiq_cls_t;

    // Execution resource an operate needs
    typedef enum logic [1:0] {
        FIQ_FU_ADD  = 2'h0,
        FIQ_FU_MUL  = 2'h1,
        FIQ_FU_DIV  = 2'h2,
        FIQ_FU_SQRT = 2'h3
    } fiq_fu_t;

endpackage
`default_nettype wire

// *** rtl/fiq_age_arb.sv ***
// Age-ordered single-grant arbiter over the queue entries.
// Assumes older[i*N+j] is set when entry j is older than entry i.
`timescale 1ns/100ps
`default_nettype none
`include "fiq_consts.svh"

module fiq_age_arb
    import fiq_pkg::*;
(
    input  wire logic [`FIQ_ENTRIES-1:0]                req,
    input  wire logic [`FIQ_ENTRIES*`FIQ_ENTRIES-1:0]   older,
    output logic      [`FIQ_ENTRIES-1:0]                gnt
);

    // An entry wins when no older entry also requests
    genvar i;
    generate
        for (i = 0; i < `FIQ_ENTRIES; i++) begin : g_ent
            assign gnt[i] = req[i] &
                ~|(req & older[i*`FIQ_ENTRIES +: `FIQ_ENTRIES]);
        end
    endgenerate

endmodule
`default_nettype wire

// *** rtl/fiq_issue_queue.sv ***
// Floating-point issue queue, arbiters, pipeline timing, register file.
// Assumes a renamer that dispatches one instruction per cycle and an
// external arithmetic datapath that supplies result values on time.
//
// Operation
// - Up to fifteen waiting instructions, one per entry.
// - Takes operates, conditional branches, stores and transfers to integer.
// - Each entry raises add, multiply and shared store requests.
// - Three arbiters; add and multiply grant at most one each cycle.
// - Store arbiter grants up to two, one per store pipeline.
// - Oldest requester always wins.
// - Stores and transfers in even entries use store port zero only.
// - Stores and transfers in odd entries use store port one only.
// - Stores and transfers request only once their source is ready.
// - Issue of a store or transfer starts its integer queue entry.
// - Multiply pipe takes one op each cycle, result after four cycles.
// - Add pipe takes one op each cycle, result after four cycles.
// - Divide and square root are unpipelined, one op at a time each.
// - Register file holds 72 physical registers.
// - Six read ports: four operand, two store data.
// - Four write ports: add, multiply and two load returns.
`timescale 1ns/100ps
`default_nettype none
`include "fiq_consts.svh"

module fiq_issue_queue
    import fiq_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    input  wire logic                          disp_valid,
    input  wire fiq_cls_t                      disp_cls,
    input  wire fiq_fu_t                       disp_fu,
    input  wire logic [`FIQ_PREG_W-1:0]        disp_src_a,
    input  wire logic [`FIQ_PREG_W-1:0]        disp_src_b,
    input  wire logic [`FIQ_PREG_W-1:0]        disp_dst,
    input  wire logic [`FIQ_IQ_IDX_W-1:0]      disp_iq_idx,
    output logic                               disp_ready,
    input  wire logic [`FIQ_DATA_W-1:0]        add_result,
    input  wire logic [`FIQ_DATA_W-1:0]        mul_result,
    input  wire logic [`FIQ_DATA_W-1:0]        dsq_result,
    input  wire logic [1:0]                    ld_wr_en,
    input  wire logic [1:0][`FIQ_PREG_W-1:0]   ld_wr_tag,
    input  wire logic [1:0][`FIQ_DATA_W-1:0]   ld_wr_data,
    output logic                               add_issue,
    output fiq_fu_t                            add_fn,
    output logic [`FIQ_DATA_W-1:0]             add_opa,
    output logic [`FIQ_DATA_W-1:0]             add_opb,
    output logic                               mul_issue,
    output logic [`FIQ_DATA_W-1:0]             mul_opa,
    output logic [`FIQ_DATA_W-1:0]             mul_opb,
    output logic [1:0]                         st_issue,
    output logic [1:0]                         st_is_xfer,
    output logic [1:0][`FIQ_DATA_W-1:0]        st_data,
    output logic [1:0]                         int_go_valid,
    output logic [1:0][`FIQ_IQ_IDX_W-1:0]      int_go_idx
);

    localparam int N = `FIQ_ENTRIES;

    // One-hot grant to entry index
    function automatic logic [`FIQ_IDX_W-1:0] fiq_enc(input logic [N-1:0] oh);
        logic [`FIQ_IDX_W-1:0] r;
        r = '0;
        for (int k = 0; k < N; k++) begin
            if (oh[k]) begin
                r = r | `FIQ_IDX_W'(k);
            end
        end
        return r;
    endfunction

    // Entry storage
    logic [N-1:0]                   valid, next_valid;
    fiq_cls_t                       cls [N];
    fiq_cls_t                       next_cls [N];
    fiq_fu_t                        fu [N];
    fiq_fu_t                        next_fu [N];
    logic [`FIQ_PREG_W-1:0]         src_a [N], next_src_a [N];
    logic [`FIQ_PREG_W-1:0]         src_b [N], next_src_b [N];
    logic [`FIQ_PREG_W-1:0]         dst [N], next_dst [N];
    logic [`FIQ_IQ_IDX_W-1:0]       iqi [N], next_iqi [N];
    logic [N*N-1:0]                 older, next_older;
    logic [`FIQ_PREGS-1:0]          sb, next_sb;
    logic [`FIQ_DATA_W-1:0]         rf [`FIQ_PREGS];
    // Pipeline timing and divide/square-root occupancy
    logic [`FIQ_ADD_LAT-1:0]        add_pv, next_add_pv, add_pw, next_add_pw;
    logic [`FIQ_PREG_W-1:0]         add_pd [`FIQ_ADD_LAT], next_add_pd [`FIQ_ADD_LAT];
    logic [`FIQ_MUL_LAT-1:0]        mul_pv, next_mul_pv;
    logic [`FIQ_PREG_W-1:0]         mul_pd [`FIQ_MUL_LAT], next_mul_pd [`FIQ_MUL_LAT];
    logic [1:0][4:0]                dsq_cnt, next_dsq_cnt;
    logic [1:0][`FIQ_PREG_W-1:0]    dsq_dst, next_dsq_dst;
    // Request and grant vectors
    logic [N-1:0]                   add_req, mul_req, st_req, add_gnt, mul_gnt;
    logic [1:0][N-1:0]              st_gnt;
    logic [1:0]                     dsq_fin;
    logic                           clash, add_we, mul_we;
    logic [`FIQ_PREG_W-1:0]         add_wt;
    logic [`FIQ_DATA_W-1:0]         add_wd;
    logic [`FIQ_IDX_W-1:0]          ag, mg;
    logic [1:0][`FIQ_IDX_W-1:0]     sg;
    logic                           accept;
    // Next values of the registered outputs
    logic                           next_add_issue, next_mul_issue, next_disp_ready_c;
    fiq_fu_t                        next_add_fn;
    logic [`FIQ_DATA_W-1:0]         next_add_opa, next_add_opb;
    logic [`FIQ_DATA_W-1:0]         next_mul_opa, next_mul_opb;
    logic [1:0]                     next_st_issue, next_st_is_xfer, next_int_go_valid;
    logic [1:0][`FIQ_DATA_W-1:0]    next_st_data;
    logic [1:0][`FIQ_IQ_IDX_W-1:0]  next_int_go_idx;

    // Request lines per entry, gated by operand readiness
    always_comb begin
        clash = (dsq_cnt[0] == `FIQ_DSQ_CLASH) || (dsq_cnt[1] == `FIQ_DSQ_CLASH);
        for (int i = 0; i < N; i++) begin
            logic rdy;
            rdy = sb[src_a[i]] & sb[src_b[i]];
            add_req[i] = valid[i] & rdy & (cls[i] == FIQ_CLS_BR ||
                (cls[i] == FIQ_CLS_OP && ((fu[i] == FIQ_FU_ADD && !clash) ||
                (fu[i] == FIQ_FU_DIV && dsq_cnt[0] == 5'h00) ||
                (fu[i] == FIQ_FU_SQRT && dsq_cnt[1] == 5'h00))));
            mul_req[i] = valid[i] & rdy & cls[i] == FIQ_CLS_OP & fu[i] == FIQ_FU_MUL;
            st_req[i]  = valid[i] & sb[src_a[i]] &
                (cls[i] == FIQ_CLS_ST || cls[i] == FIQ_CLS_FTOI);
        end
    end

    // Three arbiters; the store one split by entry parity
    fiq_age_arb u_add_arb (.req(add_req), .older(older), .gnt(add_gnt));
    fiq_age_arb u_mul_arb (.req(mul_req), .older(older), .gnt(mul_gnt));
    fiq_age_arb u_st0_arb (.req(st_req & `FIQ_EVEN_MASK), .older(older),
                           .gnt(st_gnt[0]));
    fiq_age_arb u_st1_arb (.req(st_req & `FIQ_ODD_MASK), .older(older),
                           .gnt(st_gnt[1]));
    assign ag = fiq_enc(add_gnt);
    assign mg = fiq_enc(mul_gnt);
    assign sg[0] = fiq_enc(st_gnt[0]);
    assign sg[1] = fiq_enc(st_gnt[1]);

    // Entry state: free granted entries, then fill the lowest free one
    always_comb begin
        logic [N-1:0] freed, slot;
        freed = add_gnt | mul_gnt | st_gnt[0] | st_gnt[1];
        slot = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (!valid[i]) begin
                slot = N'(1) << i;
            end
        end
        accept = disp_valid & disp_ready;
        next_valid = valid & ~freed;
        next_older = older;
        for (int i = 0; i < N; i++) begin
            next_cls[i] = cls[i];
            next_fu[i] = fu[i];
            next_src_a[i] = src_a[i];
            next_src_b[i] = src_b[i];
            next_dst[i] = dst[i];
            next_iqi[i] = iqi[i];
            if (accept && slot[i]) begin
                next_valid[i] = 1'b1;
                next_cls[i] = disp_cls;
                next_fu[i] = disp_fu;
                next_src_a[i] = disp_src_a;
                next_src_b[i] = disp_src_b;
                next_dst[i] = disp_dst;
                next_iqi[i] = disp_iq_idx;
                next_older[i*N +: N] = valid & ~freed;
                for (int j = 0; j < N; j++) begin
                    next_older[j*N + i] = 1'b0;
                end
            end
        end
    end

    // Pipeline timing and unpipelined divide/square-root units
    always_comb begin
        next_add_pv = {add_pv[`FIQ_ADD_LAT-2:0], 1'b0};
        next_add_pw = {add_pw[`FIQ_ADD_LAT-2:0], 1'b0};
        next_mul_pv = {mul_pv[`FIQ_MUL_LAT-2:0], |mul_gnt};
        for (int s = `FIQ_ADD_LAT - 1; s > 0; s--) begin
            next_add_pd[s] = add_pd[s-1];
            next_mul_pd[s] = mul_pd[s-1];
        end
        next_add_pd[0] = dst[ag];
        next_mul_pd[0] = dst[mg];
        next_dsq_dst = dsq_dst;
        for (int u = 0; u < 2; u++) begin
            dsq_fin[u] = (dsq_cnt[u] == 5'h01);
            next_dsq_cnt[u] = (dsq_cnt[u] != 5'h00) ? dsq_cnt[u] - 5'h01 : 5'h00;
        end
        if (|add_gnt) begin
            if (cls[ag] == FIQ_CLS_OP && fu[ag] == FIQ_FU_DIV) begin
                next_dsq_cnt[0] = `FIQ_DSQ_LAT;
                next_dsq_dst[0] = dst[ag];
            end else if (cls[ag] == FIQ_CLS_OP && fu[ag] == FIQ_FU_SQRT) begin
                next_dsq_cnt[1] = `FIQ_DSQ_LAT;
                next_dsq_dst[1] = dst[ag];
            end else begin
                next_add_pv[0] = 1'b1;
                next_add_pw[0] = (cls[ag] == FIQ_CLS_OP);
            end
        end
        // Add write port, shared with the divide and square-root units
        add_we = (add_pv[`FIQ_ADD_LAT-1] & add_pw[`FIQ_ADD_LAT-1]) | (|dsq_fin);
        add_wt = dsq_fin[0] ? dsq_dst[0] :
                 dsq_fin[1] ? dsq_dst[1] : add_pd[`FIQ_ADD_LAT-1];
        add_wd = (|dsq_fin) ? dsq_result : add_result;
        mul_we = mul_pv[`FIQ_MUL_LAT-1];
        // Scoreboard: cleared for an operate's destination, set on any write
        next_sb = sb;
        if (accept && disp_cls == FIQ_CLS_OP) next_sb[disp_dst] = 1'b0; // Others write nothing
        if (add_we) next_sb[add_wt] = 1'b1;
        if (mul_we) next_sb[mul_pd[`FIQ_MUL_LAT-1]] = 1'b1;
        for (int p = 0; p < 2; p++) begin
            if (ld_wr_en[p]) next_sb[ld_wr_tag[p]] = 1'b1;
        end
    end

    // Register file read ports feeding the issue outputs
    always_comb begin
        next_disp_ready_c = ~&next_valid;
        next_add_issue = |add_gnt;
        next_add_fn = (cls[ag] == FIQ_CLS_OP) ? fu[ag] : FIQ_FU_ADD;
        next_add_opa = rf[src_a[ag]];
        next_add_opb = rf[src_b[ag]];
        next_mul_issue = |mul_gnt;
        next_mul_opa = rf[src_a[mg]];
        next_mul_opb = rf[src_b[mg]];
        for (int p = 0; p < 2; p++) begin
            next_st_issue[p] = |st_gnt[p];
            next_st_is_xfer[p] = (cls[sg[p]] == FIQ_CLS_FTOI);
            next_st_data[p] = rf[src_a[sg[p]]];
            next_int_go_valid[p] = |st_gnt[p];
            next_int_go_idx[p] = iqi[sg[p]];
        end
    end

    // Register the resettable state and all outputs
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            valid <= '0;
            older <= '0;
            sb <= '1;
            add_pv <= '0;
            add_pw <= '0;
            mul_pv <= '0;
            dsq_cnt <= '0;
            dsq_dst <= '0;
            disp_ready <= 1'b1;
            add_issue <= 1'b0;
            add_fn <= FIQ_FU_ADD;
            add_opa <= '0;
            add_opb <= '0;
            mul_issue <= 1'b0;
            mul_opa <= '0;
            mul_opb <= '0;
            st_issue <= '0;
            st_is_xfer <= '0;
            st_data <= '0;
            int_go_valid <= '0;
            int_go_idx <= '0;
        end else begin
            valid <= next_valid;
            older <= next_older;
            sb <= next_sb;
            add_pv <= next_add_pv;
            add_pw <= next_add_pw;
            mul_pv <= next_mul_pv;
            dsq_cnt <= next_dsq_cnt;
            dsq_dst <= next_dsq_dst;
            disp_ready <= next_disp_ready_c;
            add_issue <= next_add_issue;
            add_fn <= next_add_fn;
            add_opa <= next_add_opa;
            add_opb <= next_add_opb;
            mul_issue <= next_mul_issue;
            mul_opa <= next_mul_opa;
            mul_opb <= next_mul_opb;
            st_issue <= next_st_issue;
            st_is_xfer <= next_st_is_xfer;
            st_data <= next_st_data;
            int_go_valid <= next_int_go_valid;
            int_go_idx <= next_int_go_idx;
        end
    end

    // Entry payload and pipeline tags need no reset; valid bits guard them
    always_ff @(posedge clock) begin
        cls <= next_cls;
        fu <= next_fu;
        src_a <= next_src_a;
        src_b <= next_src_b;
        dst <= next_dst;
        iqi <= next_iqi;
        add_pd <= next_add_pd;
        mul_pd <= next_mul_pd;
    end

    // Register file: 72 entries, add, multiply and two load write ports
    always_ff @(posedge clock) begin
        if (add_we) rf[add_wt] <= add_wd;
        if (mul_we) rf[mul_pd[`FIQ_MUL_LAT-1]] <= mul_result;
        for (int p = 0; p < 2; p++) begin
            if (ld_wr_en[p]) rf[ld_wr_tag[p]] <= ld_wr_data[p];
        end
    end

    // Checks on arbitration, latency and entry release
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_ADD_ONE: assert property ($onehot0(add_gnt) && $onehot0(mul_gnt))
        else $error("add or multiply arbiter granted two entries");
    AST_ST_EVEN: assert property ((st_gnt[0] & `FIQ_ODD_MASK) == '0 && $onehot0(st_gnt[0]))
        else $error("store port zero granted an odd entry");
    AST_ST_ODD: assert property ((st_gnt[1] & `FIQ_EVEN_MASK) == '0 && $onehot0(st_gnt[1]))
        else $error("store port one granted an even entry");
    AST_OLDEST: assert property (|add_gnt |-> (add_req & older[ag*N +: N]) == '0)
        else $error("younger add requester beat an older one");
    AST_MUL_LAT: assert property (|mul_gnt |-> ##1 mul_issue ##3 mul_we)
        else $error("multiply result not written four cycles after grant");
    AST_ADD_LAT: assert property (|add_gnt && cls[ag] == FIQ_CLS_OP && fu[ag] == FIQ_FU_ADD
        |-> ##4 add_we)
        else $error("add result not written four cycles after grant");
    AST_FREE: assert property (|add_gnt |=> !valid[$past(ag)])
        else $error("granted entry still valid next cycle");
    AST_INT_GO: assert property (st_gnt[1] != '0 |=> int_go_valid[1]
        && int_go_idx[1] == $past(iqi[sg[1]]))
        else $error("integer queue not signalled on store issue");
    AST_DSQ: assert property (dsq_cnt[0] != 5'h00 |-> !(add_gnt[ag] && fu[ag] == FIQ_FU_DIV
        && cls[ag] == FIQ_CLS_OP && |add_gnt))
        else $error("divide started while busy");
    COV_DUAL_ST: cover property (st_gnt[0] != '0 && st_gnt[1] != '0);
    COV_FULL: cover property (valid == '1);
    COV_DIV: cover property (dsq_fin[0]);
endmodule
`default_nettype wire

// *** verif/fiq_pipe_model.sv ***
// Behavioural model of one floating-point result pipeline at the far side.
// Assumes issue and operands come from registers of the queue.
`timescale 1ns/100ps
`default_nettype none

module fiq_pipe_model #(
    parameter int LAT  = 4,
    parameter int KIND = 0
) (
    input  wire logic        clock,
    input  wire logic        issue,
    input  wire logic [63:0] opa,
    input  wire logic [63:0] opb,
    output logic      [63:0] result
);
    logic [LAT-2:0] vld  = '0;
    logic [63:0]    val  [LAT-1];
    logic [63:0]    last = '0;

    // One stage a cycle; the last stage is the write cycle
    always @(posedge clock) begin
        vld[0] <= issue;
        val[0] <= (KIND == 0) ? opa + opb : (KIND == 1) ? opa * opb : opa - opb;
        for (int i = 1; i < LAT - 1; i++) begin
            vld[i] <= vld[i-1];
            val[i] <= val[i-1];
        end
        if (vld[LAT-2]) begin
            last <= val[LAT-2];
        end
    end

    // Outside the write cycle the bus shows the inverse of the last result
    assign result = vld[LAT-2] ? val[LAT-2] : ~last;

endmodule

`default_nettype wire

// *** verif/fp_issue_queue_scheduler_tb.sv ***
// Self-checking bench for the floating-point issue queue.
// Assumes the result pipelines are modelled at the far side.
`timescale 1ns/100ps
`default_nettype none
`include "fiq_consts.svh"

module fp_issue_queue_scheduler_tb
    import fiq_pkg::*;
;
    localparam logic [63:0] VA = 64'h11;
    localparam logic [63:0] VB = 64'h2222;

    logic                  clock = 1'b0;
    logic                  rst_b, disp_valid, disp_ready, add_issue, mul_issue;
    fiq_cls_t              disp_cls;
    fiq_fu_t               disp_fu, add_fn;
    logic [6:0]            disp_src_a, disp_src_b, disp_dst;
    logic [4:0]            disp_iq_idx;
    logic [63:0]           add_result, mul_result, dsq_result;
    logic [63:0]           add_opa, add_opb, mul_opa, mul_opb;
    logic [1:0]            ld_wr_en, st_issue, st_is_xfer, int_go_valid;
    logic [1:0][6:0]       ld_wr_tag;
    logic [1:0][63:0]      ld_wr_data, st_data;
    logic [1:0][4:0]       int_go_idx;
    int                    failures, cmp_count, cyc;
    wire logic             add_go = add_issue & (add_fn == FIQ_FU_ADD);
    wire logic             dsq_go = add_issue & (add_fn == FIQ_FU_DIV | add_fn == FIQ_FU_SQRT);

    fiq_issue_queue dut_u (.clock, .rst_b, .disp_valid, .disp_cls, .disp_fu, .disp_src_a,
        .disp_src_b, .disp_dst, .disp_iq_idx, .disp_ready, .add_result, .mul_result,
        .dsq_result, .ld_wr_en, .ld_wr_tag, .ld_wr_data, .add_issue, .add_fn, .add_opa,
        .add_opb, .mul_issue, .mul_opa, .mul_opb, .st_issue, .st_is_xfer, .st_data,
        .int_go_valid, .int_go_idx);

    // Far-side result pipelines
    fiq_pipe_model #(.LAT(`FIQ_ADD_LAT), .KIND(0)) add_m (.clock, .issue(add_go),
        .opa(add_opa), .opb(add_opb), .result(add_result));
    fiq_pipe_model #(.LAT(`FIQ_MUL_LAT), .KIND(1)) mul_m (.clock, .issue(mul_issue),
        .opa(mul_opa), .opb(mul_opb), .result(mul_result));
    fiq_pipe_model #(.LAT(`FIQ_DSQ_LAT), .KIND(2)) dsq_m (.clock, .issue(dsq_go),
        .opa(add_opa), .opb(add_opb), .result(dsq_result));

    // Clock and cycle ceiling
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Offers one instruction once a free entry is shown; valid stays up
    task automatic disp(input fiq_cls_t c, input fiq_fu_t f, input logic [6:0] a,
                        input logic [6:0] b, input logic [6:0] d, input logic [4:0] q);
        for (int n = 0; n < 200 && disp_ready !== 1'b1; n++)
            @(negedge clock);
        chk(disp_ready, 64'h1);
        disp_valid = 1'b1;
        disp_cls = c;
        disp_fu = f;
        disp_src_a = a;
        disp_src_b = b;
        disp_dst = d;
        disp_iq_idx = q;
        @(negedge clock);
    endtask

    // Waits for an add (0), multiply (1) or store (2) issue pulse
    task automatic wait_sig(input int w, output int t);
        int n;
        n = 0;
        while (n < 100 && !(w == 0 ? add_issue === 1'b1 :
                            w == 1 ? mul_issue === 1'b1 : st_issue !== 2'h0)) begin
            @(negedge clock);
            n++;
        end
        chk(64'(n < 100), 64'h1);
        t = cyc;
    endtask

    task automatic check_reset();
        chk(disp_ready, 64'h1);
        chk({add_issue, mul_issue, st_issue, int_go_valid}, 64'h0);
    endtask

    task automatic test_add();
        int t0;
        int t1;
        ld_wr_en = 2'h3;
        ld_wr_tag = {7'h02, 7'h01};
        ld_wr_data = {VB, VA};
        @(negedge clock);
        ld_wr_en = 2'h0;
        disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h01, 7'h02, 7'h03, 5'h00);
        disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h03, 7'h01, 7'h04, 5'h00);
        disp_valid = 1'b0;
        wait_sig(0, t0);
        chk(add_opa, VA);
        chk(add_opb, VB);
        @(negedge clock);
        wait_sig(0, t1);
        chk(add_opa, VA + VB);
        chk(64'(t1 - t0), 64'h5);
    endtask

    task automatic test_mul();
        int t0;
        int t1;
        disp(FIQ_CLS_OP, FIQ_FU_MUL, 7'h01, 7'h02, 7'h05, 5'h00);
        disp(FIQ_CLS_OP, FIQ_FU_MUL, 7'h02, 7'h02, 7'h06, 5'h00);
        disp_valid = 1'b0;
        wait_sig(1, t0);
        chk(mul_opa, VA);
        @(negedge clock);
        chk(mul_issue, 64'h1);
        chk(mul_opb, VB);
        disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h05, 7'h06, 7'h07, 5'h00);
        disp_valid = 1'b0;
        wait_sig(0, t1);
        chk(add_opa, VA * VB);
        chk(add_opb, VB * VB);
        chk(64'(t1 - t0), 64'h6);
    endtask

    task automatic test_store();
        int t0;
        disp(FIQ_CLS_OP, FIQ_FU_MUL, 7'h01, 7'h01, 7'h08, 5'h00);
        disp_valid = 1'b0;
        repeat (2) @(negedge clock);
        // Entry 0 then entry 1, both waiting on the multiply result
        disp(FIQ_CLS_FTOI, FIQ_FU_ADD, 7'h08, 7'h08, 7'h00, 5'h03);
        disp(FIQ_CLS_ST, FIQ_FU_ADD, 7'h08, 7'h08, 7'h00, 5'h04);
        disp(FIQ_CLS_BR, FIQ_FU_ADD, 7'h01, 7'h01, 7'h00, 5'h00);
        disp_valid = 1'b0;
        wait_sig(2, t0);
        chk(st_issue, 64'h3);
        chk(st_is_xfer, 64'h1);
        chk(st_data[0], VA * VA);
        chk(st_data[1], VA * VA);
        chk(int_go_valid, 64'h3);
        chk({int_go_idx[1], int_go_idx[0]}, 64'h83);
        wait_sig(0, t0);
        chk(add_issue, 64'h1);
    endtask

    task automatic test_divide();
        int t0;
        int t1;
        disp(FIQ_CLS_OP, FIQ_FU_DIV, 7'h01, 7'h02, 7'h0B, 5'h00);
        disp_valid = 1'b0;
        wait_sig(0, t0);
        chk(add_fn, FIQ_FU_DIV);
        @(negedge clock);
        // Second divide in entry 0 stalls; a dependent add lands in entry 1
        disp(FIQ_CLS_OP, FIQ_FU_DIV, 7'h02, 7'h01, 7'h0C, 5'h00);
        disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h0C, 7'h01, 7'h0D, 5'h00);
        disp_valid = 1'b0;
        wait_sig(0, t1);
        chk(64'(t1 - t0 >= `FIQ_DSQ_LAT), 64'h1);
        @(negedge clock);
        disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h0C, 7'h02, 7'h0E, 5'h00);
        disp_valid = 1'b0;
        wait_sig(0, t0);
        chk(add_opa, VB - VA);
        chk(add_opb, VA);
        @(negedge clock);
        wait_sig(0, t0);
        chk(add_opb, VB);
    endtask

    task automatic test_full();
        int n;
        disp(FIQ_CLS_OP, FIQ_FU_DIV, 7'h01, 7'h02, 7'h1E, 5'h00);
        disp(FIQ_CLS_OP, FIQ_FU_DIV, 7'h01, 7'h02, 7'h1F, 5'h00);
        disp(FIQ_CLS_OP, FIQ_FU_SQRT, 7'h1F, 7'h1F, 7'h20, 5'h00);
        for (int i = 0; i < 14; i++)
            disp(FIQ_CLS_OP, FIQ_FU_ADD, 7'h20, 7'h01, 7'h21, 5'h00);
        disp_valid = 1'b0;
        repeat (2) @(negedge clock);
        chk(disp_ready, 64'h0);
        // Offer a ready add while full; it must be ignored
        disp_valid = 1'b1;
        disp_src_a = 7'h01;
        @(negedge clock);
        disp_valid = 1'b0;
        n = 0;
        repeat (80) begin
            @(negedge clock);
            n += add_issue;
        end
        chk(64'(n), 64'hF);
        chk(disp_ready, 64'h1);
    endtask

    initial begin
        rst_b = 1'b0;
        disp_valid = 1'b0;
        disp_cls = FIQ_CLS_OP;
        disp_fu = FIQ_FU_ADD;
        disp_src_a = 7'h00;
        disp_src_b = 7'h00;
        disp_dst = 7'h00;
        disp_iq_idx = 5'h00;
        ld_wr_en = 2'h0;
        ld_wr_tag = '0;
        ld_wr_data = '0;
        repeat (10) @(negedge clock);
        check_reset();
        rst_b = 1'b1;
        @(negedge clock);
        test_add();
        test_mul();
        test_store();
        test_divide();
        test_full();
        print_verdict();
    end

endmodule

`default_nettype wire
